// >>> rtl/mbr_handler.sv
`timescale 1ns/1ns
// How it works
// R1: function 10h writes the carried 16-bit values to consecutive registers from the start.
// R2: a write request holds start, count N, byte count 2N, N values; length is 7 plus 2N.
// R3: the write count must lie in 1..7Bh.
// R4: a good write is answered with 10h, echoed start and count, length 6.
// R5: a failed write is answered with 90h and one exception byte, length 3.
// R6: exception bytes are only 1, 2, 3 or 4.
// R7: function 17h writes one range and reads another, returning the values read.
// R8: a read/write request holds read start, read count, write start, write count, byte count, values; length Bh plus twice the count.
// R9: read and write counts of function 17h must lie in 1..79h.
// R10: the read/write answer holds byte count 2M and M values; length 3 plus 2M.
// R11: a failed read/write is answered with 97h and one exception byte, length 3.
// R12: every two-byte field travels high byte first.
// R13: both functions reach any address of the register space, program and process data alike.
// R14: the protocol identifier is always zero.
// R15: the unit identifier is always zero.
// R16: the length field counts unit identifier, function code and all following bytes.
// R17: a bad count, byte count or length gives an exception and no register access. Frame size is checked against the length only after the writes.
module mbr_handler (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  // request byte stream
  input wire mbr_pkg::mbr_byte_t RX_IN,
  input wire logic RX_VALID_IN,
  output logic RX_READY_OUT,
  // response byte stream
  output mbr_pkg::mbr_byte_t TX_OUT,
  output logic TX_VALID_OUT,
  input wire logic TX_READY_IN,
  // register space
  output mbr_pkg::mbr_wr_t WR_OUT,
  output mbr_pkg::mbr_rd_t RD_OUT,
  input wire logic [15:0] RD_DATA_IN
);
  import mbr_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  mbr_state_t st_reg, st_next;
  logic [8:0] idx_reg, idx_next, pos_reg, pos_next;
  logic [15:0] tid_reg, tid_next, len_reg, len_next, wk_reg, wk_next;
  logic [7:0] fc_reg, fc_next, exc_reg, exc_next, hi_reg, hi_next, lo_reg, lo_next;
  logic [63:0] f_reg, f_next;
  logic have_hi_reg, have_hi_next, done_reg, done_next;
  logic txv_reg, txv_next;
  mbr_byte_t txd_reg, txd_next;
  mbr_wr_t wr_reg, wr_next;
  mbr_rd_t rd_reg, rd_next;

  logic rx_take, tx_load;
  logic [8:0] bc_idx, out_pos;
  logic [15:0] wcnt, rcnt, len_out;
  logic [7:0] b, tb;

  assign RX_READY_OUT = (st_reg != MBR_TX);
  assign rx_take = RX_READY_OUT && RX_VALID_IN;
  assign tx_load = (st_reg == MBR_TX) && !done_reg && (!txv_reg || TX_READY_IN);
  assign bc_idx = (fc_reg == FC_READ_WRITE) ? IDX_RW_BC : IDX_WR_BC;
  assign wcnt = f_reg[15:0];
  assign rcnt = f_reg[47:32];
  assign out_pos = pos_reg - 9'h001;
  assign b = RX_IN.data;
  assign TX_OUT = txd_reg;
  assign TX_VALID_OUT = txv_reg;
  assign WR_OUT = wr_reg;
  assign RD_OUT = rd_reg;

  // ************************************************************
  // response length and next response byte
  // ************************************************************
  always_comb begin
    if (exc_reg != EXC_NONE) begin
      len_out = ERR_RSP_LEN;
    end else if (fc_reg == FC_WRITE_MULTI) begin
      len_out = WR_RSP_LEN; // R4
    end else begin
      len_out = RD_RSP_LEN_BASE + {rcnt[14:0], 1'b0}; // R10
    end
  end

  always_comb begin
    tb = 8'h00;
    case (pos_reg)
      IDX_TID_HI: tb = tid_reg[15:8]; // R12
      IDX_TID_LO: tb = tid_reg[7:0];
      IDX_LEN_HI: tb = len_out[15:8];
      IDX_LEN_LO: tb = len_out[7:0];
      IDX_FC: tb = (exc_reg != EXC_NONE) ? (fc_reg | EXC_FLAG) : fc_reg; // R5 R11
      IDX_PID_HI, IDX_PID_LO, IDX_UID: tb = 8'h00; // R14 R15
      default: begin
        if (exc_reg != EXC_NONE) begin
          tb = exc_reg; // R6
        end else if (fc_reg == FC_WRITE_MULTI) begin
          tb = 8'(f_reg[31:0] >> {2'h3 - pos_reg[1:0], 3'h0}); // R4 R12
        end else if (pos_reg == IDX_FIELDS) begin
          tb = {rcnt[6:0], 1'b0}; // R10
        end else if (pos_reg[0]) begin
          tb = RD_DATA_IN[15:8]; // R7 R12
        end else begin
          tb = lo_reg;
        end
      end
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    idx_next = idx_reg;
    pos_next = pos_reg;
    tid_next = tid_reg;
    len_next = len_reg;
    wk_next = wk_reg;
    fc_next = fc_reg;
    exc_next = exc_reg;
    hi_next = hi_reg;
    lo_next = lo_reg;
    f_next = f_reg;
    have_hi_next = have_hi_reg;
    done_next = done_reg;
    txv_next = txv_reg;
    txd_next = txd_reg;
    wr_next = '0;
    rd_next = '{en: 1'b0, addr: rd_reg.addr};
    if (rx_take) begin
      if (idx_reg != IDX_LAST) begin
        idx_next = idx_reg + 9'h001;
      end
      case (idx_reg)
        IDX_TID_HI: tid_next[15:8] = b;
        IDX_TID_LO: tid_next[7:0] = b;
        IDX_LEN_HI: len_next[15:8] = b; // R12
        IDX_LEN_LO: len_next[7:0] = b;
        IDX_FC: begin
          fc_next = b;
          if (b != FC_WRITE_MULTI && b != FC_READ_WRITE) begin
            exc_next = EXC_ILLEGAL_FUNC; // R6
          end
        end
        default: ;
      endcase
      if ((idx_reg == IDX_PID_HI || idx_reg == IDX_PID_LO || idx_reg == IDX_UID) &&
          b != 8'h00) begin
        st_next = MBR_SKIP; // R14 R15
      end
      if (idx_reg >= IDX_FIELDS && idx_reg < bc_idx) begin
        f_next = {f_reg[55:0], b}; // R12
      end
      if (idx_reg == bc_idx && exc_reg == EXC_NONE) begin
        if (fc_reg == FC_WRITE_MULTI) begin
          if (wcnt == 16'h0000 || wcnt > WR_MAX_CNT || b != {wcnt[6:0], 1'b0} || // R3
              len_reg != WR_LEN_BASE + {wcnt[14:0], 1'b0}) begin // R2 R16
            exc_next = EXC_ILLEGAL_VALUE; // R17
          end
        end else if (rcnt == 16'h0000 || rcnt > RW_MAX_CNT || wcnt == 16'h0000 || // R9
                     wcnt > RW_MAX_CNT || b != {wcnt[6:0], 1'b0} ||
                     len_reg != RW_LEN_BASE + {wcnt[14:0], 1'b0}) begin // R8 R16
          exc_next = EXC_ILLEGAL_VALUE; // R17
        end
      end
      if (idx_reg > bc_idx && exc_reg == EXC_NONE && wk_reg < wcnt &&
          st_reg == MBR_RX) begin // R14 R15
        if (!have_hi_reg) begin
          hi_next = b; // R12
          have_hi_next = 1'b1;
        end else begin
          // any address, program or process data alike
          wr_next = '{en: 1'b1, addr: f_reg[31:16] + wk_reg, data: {hi_reg, b}}; // R1 R7 R13
          wk_next = wk_reg + 16'h0001;
          have_hi_next = 1'b0;
        end
      end
      if (RX_IN.last) begin
        if (st_next == MBR_SKIP || st_reg == MBR_SKIP || idx_reg < IDX_FC) begin
          st_next = MBR_RX;
          idx_next = IDX_TID_HI;
          exc_next = EXC_NONE;
          wk_next = 16'h0000;
          have_hi_next = 1'b0;
        end else begin
          if (exc_next == EXC_NONE &&
              (idx_reg < bc_idx || 16'(idx_reg) + 16'h0001 != len_reg + LEN_OFFSET)) begin
            exc_next = EXC_ILLEGAL_VALUE; // R16 R17
          end
          st_next = MBR_TX;
          pos_next = IDX_TID_HI;
          done_next = 1'b0;
          rd_next.addr = f_reg[63:48]; // R7
        end
      end
    end
    if (txv_reg && TX_READY_IN) begin
      txv_next = 1'b0;
      if (txd_reg.last) begin
        st_next = MBR_RX;
        idx_next = IDX_TID_HI;
        exc_next = EXC_NONE;
        wk_next = 16'h0000;
        have_hi_next = 1'b0;
      end
    end
    if (tx_load) begin
      txv_next = 1'b1;
      txd_next.data = tb;
      txd_next.last = (16'(pos_reg) == len_out + LEN_OFFSET - 16'h0001);
      done_next = txd_next.last;
      pos_next = pos_reg + 9'h001;
      if (exc_reg == EXC_NONE && fc_reg == FC_READ_WRITE && pos_reg > IDX_FIELDS &&
          pos_reg[0]) begin
        lo_next = RD_DATA_IN[7:0]; // R7
        rd_next = '{en: 1'b1, addr: rd_reg.addr + 16'h0001};
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_reg <= MBR_RX;
      idx_reg <= '0;
      pos_reg <= '0;
      tid_reg <= '0;
      len_reg <= '0;
      wk_reg <= '0;
      fc_reg <= '0;
      exc_reg <= EXC_NONE;
      hi_reg <= '0;
      lo_reg <= '0;
      f_reg <= '0;
      have_hi_reg <= 1'b0;
      done_reg <= 1'b0;
      txv_reg <= 1'b0;
      txd_reg <= '0;
      wr_reg <= '0;
      rd_reg <= '0;
    end else if (CE_IN) begin
      st_reg <= st_next;
      idx_reg <= idx_next;
      pos_reg <= pos_next;
      tid_reg <= tid_next;
      len_reg <= len_next;
      wk_reg <= wk_next;
      fc_reg <= fc_next;
      exc_reg <= exc_next;
      hi_reg <= hi_next;
      lo_reg <= lo_next;
      f_reg <= f_next;
      have_hi_reg <= have_hi_next;
      done_reg <= done_next;
      txv_reg <= txv_next;
      txd_reg <= txd_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_wr_within_count: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R1
    WR_OUT.en |-> (wk_reg != 16'h0000 && wk_reg <= wcnt))
    else $error("write beyond register count");
  a_wr_after_check: assert property (@(posedge CLK_IN) disable iff (RST_IN || !CE_IN) // R17
    WR_OUT.en |-> $past(exc_reg) == EXC_NONE)
    else $error("write issued for a refused request");
  a_len16_frame: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R2
    (st_reg == MBR_TX && exc_reg == EXC_NONE && fc_reg == FC_WRITE_MULTI) |->
      len_reg == WR_LEN_BASE + {wcnt[14:0], 1'b0})
    else $error("write accepted with wrong length");
  a_cnt16_range: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R3
    (st_reg == MBR_TX && exc_reg == EXC_NONE && fc_reg == FC_WRITE_MULTI) |->
      (wcnt != 16'h0000 && wcnt <= WR_MAX_CNT))
    else $error("write count out of range accepted");
  a_len16_reply: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R4
    (TX_VALID_OUT && out_pos == IDX_LEN_LO && fc_reg == FC_WRITE_MULTI &&
     exc_reg == EXC_NONE) |-> TX_OUT.data == WR_RSP_LEN[7:0])
    else $error("write reply length wrong");
  a_err16_code: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R5
    (TX_VALID_OUT && out_pos == IDX_FC && fc_reg == FC_WRITE_MULTI &&
     exc_reg != EXC_NONE) |-> TX_OUT.data == (FC_WRITE_MULTI | EXC_FLAG))
    else $error("write error code wrong");
  a_exc_range: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R6
    (TX_VALID_OUT && out_pos == IDX_FIELDS && exc_reg != EXC_NONE) |->
      (TX_OUT.data != 8'h00 && TX_OUT.data <= EXC_MAX && TX_OUT.last))
    else $error("exception byte out of range");
  a_cnt23_range: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R9
    (st_reg == MBR_TX && exc_reg == EXC_NONE && fc_reg == FC_READ_WRITE) |->
      (rcnt != 16'h0000 && rcnt <= RW_MAX_CNT && wcnt != 16'h0000 && wcnt <= RW_MAX_CNT))
    else $error("read/write count out of range accepted");
  a_len23_frame: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R8
    (st_reg == MBR_TX && exc_reg == EXC_NONE && fc_reg == FC_READ_WRITE) |->
      len_reg == RW_LEN_BASE + {wcnt[14:0], 1'b0})
    else $error("read/write accepted with wrong length");
  a_rw_bytecount: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R10
    (TX_VALID_OUT && out_pos == IDX_FIELDS && fc_reg == FC_READ_WRITE &&
     exc_reg == EXC_NONE) |-> TX_OUT.data == {rcnt[6:0], 1'b0})
    else $error("read/write byte count wrong");
  a_err23_code: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R11
    (TX_VALID_OUT && out_pos == IDX_FC && fc_reg == FC_READ_WRITE &&
     exc_reg != EXC_NONE) |-> TX_OUT.data == (FC_READ_WRITE | EXC_FLAG))
    else $error("read/write error code wrong");
  a_echo_high_first: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R12
    (TX_VALID_OUT && out_pos == IDX_FIELDS && fc_reg == FC_WRITE_MULTI &&
     exc_reg == EXC_NONE) |-> TX_OUT.data == f_reg[31:24])
    else $error("start address not high byte first");
  a_hdr_zero: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R14
    (TX_VALID_OUT && (out_pos == IDX_PID_HI || out_pos == IDX_PID_LO)) |->
      TX_OUT.data == 8'h00)
    else $error("protocol identifier not zero");
  a_uid_zero: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R15
    (TX_VALID_OUT && out_pos == IDX_UID) |-> TX_OUT.data == 8'h00)
    else $error("unit identifier not zero");
  a_wr_not_dropped: assert property (@(posedge CLK_IN) disable iff (RST_IN) // R14 R15
    WR_OUT.en |-> st_reg != MBR_SKIP)
    else $error("write issued for a dropped frame");
endmodule

// >>> rtl/mbr_pkg.sv
package mbr_pkg;
  // ************************************************************
  // function and exception codes
  // ************************************************************
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] FC_READ_WRITE = 8'h17;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [7:0] EXC_MAX = 8'h04;
  // ************************************************************
  // counts and length fields
  // ************************************************************
  localparam logic [15:0] WR_MAX_CNT = 16'h007B;
  localparam logic [15:0] RW_MAX_CNT = 16'h0079;
  localparam logic [15:0] WR_LEN_BASE = 16'h0007;
  localparam logic [15:0] RW_LEN_BASE = 16'h000B;
  localparam logic [15:0] WR_RSP_LEN = 16'h0006;
  localparam logic [15:0] ERR_RSP_LEN = 16'h0003;
  localparam logic [15:0] RD_RSP_LEN_BASE = 16'h0003;
  localparam logic [15:0] LEN_OFFSET = 16'h0006;
  // ************************************************************
  // byte positions within a frame
  // ************************************************************
  localparam logic [8:0] IDX_TID_HI = 9'h000;
  localparam logic [8:0] IDX_TID_LO = 9'h001;
  localparam logic [8:0] IDX_PID_HI = 9'h002;
  localparam logic [8:0] IDX_PID_LO = 9'h003;
  localparam logic [8:0] IDX_LEN_HI = 9'h004;
  localparam logic [8:0] IDX_LEN_LO = 9'h005;
  localparam logic [8:0] IDX_UID = 9'h006;
  localparam logic [8:0] IDX_FC = 9'h007;
  localparam logic [8:0] IDX_FIELDS = 9'h008;
  localparam logic [8:0] IDX_WR_BC = 9'h00C;
  localparam logic [8:0] IDX_RW_BC = 9'h010;
  localparam logic [8:0] IDX_LAST = 9'h1FF;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    MBR_RX = 2'b00,
    MBR_TX = 2'b01,
    MBR_SKIP = 2'b10
  } mbr_state_t;
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } mbr_byte_t;
  typedef struct packed {
    logic en;
    logic [15:0] addr;
    logic [15:0] data;
  } mbr_wr_t;
  typedef struct packed {
    logic en;
    logic [15:0] addr;
  } mbr_rd_t;
endpackage

// >>> tb/mbr_reg_model.sv
`timescale 1ns/1ns
module mbr_reg_model (
  // clock
  input wire logic clk_in,
  // register access from the handler
  input wire mbr_pkg::mbr_wr_t wr_in,
  input wire mbr_pkg::mbr_rd_t rd_in,
  output logic [15:0] rd_data_out
);
  import mbr_pkg::*;
  logic [15:0] mem [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 16'(i) ^ 16'hA5C3;
    end
  end
  // read value follows the address in the same cycle
  assign rd_data_out = mem[rd_in.addr];
  always @(posedge clk_in) begin
    if (wr_in.en) begin
      mem[wr_in.addr] <= wr_in.data;
    end
  end
endmodule

// >>> tb/mbr_handler_tb.sv
`timescale 1ns/1ns
module mbr_handler_tb;
  import mbr_pkg::*;
  // ****************
  // signals
  // ****************
  logic clk, rst, ce, rx_valid, rx_ready, tx_valid, tx_ready;
  mbr_byte_t rx, tx;
  mbr_wr_t wr;
  mbr_rd_t rd;
  logic [15:0] rd_data;
  int n_errors, samples_checked, cycles;
  int n_wr, n_rd;
  logic [15:0] len_adj;
  int seed = 92484;
  logic [15:0] ref_mem [0:65535];
  logic [7:0] req[$];
  mbr_byte_t exp_q[$], got[$];
  logic [15:0] ra;

  mbr_handler u_dut (.CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .RX_IN(rx),
    .RX_VALID_IN(rx_valid), .RX_READY_OUT(rx_ready), .TX_OUT(tx), .TX_VALID_OUT(tx_valid),
    .TX_READY_IN(tx_ready), .WR_OUT(wr), .RD_OUT(rd), .RD_DATA_IN(rd_data));
  mbr_reg_model u_reg (.clk_in(clk), .wr_in(wr), .rd_in(rd), .rd_data_out(rd_data));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // random clock enable and sink stalls
  always @(posedge clk) begin
    #1;
    ce = ($random(seed) & 7) != 0;
    tx_ready = ($random(seed) & 3) != 0;
  end
  always @(posedge clk) begin
    if (!rst && ce && tx_valid && tx_ready) begin
      got.push_back(tx);
    end
    if (!rst && ce && wr.en) n_wr++;
    if (!rst && ce && rd.en) n_rd++;
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      give_verdict();
    end
  end
  // ****************
  // tasks
  // ****************
  task automatic give_verdict();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic r16(input logic [15:0] x);
    req.push_back(x[15:8]);
    req.push_back(x[7:0]);
  endtask
  task automatic e8(input logic [7:0] x);
    exp_q.push_back('{data: x, last: 1'b0});
  endtask
  task automatic e16(input logic [15:0] x);
    e8(x[15:8]);
    e8(x[7:0]);
  endtask
  task automatic frame(input logic [7:0] fc, input logic [15:0] a1, input logic [15:0] n1,
    input logic [15:0] a2, input logic [15:0] n2, input logic [7:0] bc_adj,
    input logic [15:0] pid, input logic [7:0] uid, input string name);
    logic [15:0] tid, len, v, n, wa;
    logic isfc, ok;
    int t;
    tid = 16'($random(seed));
    isfc = fc == FC_WRITE_MULTI || fc == FC_READ_WRITE;
    n = (fc == FC_READ_WRITE) ? n2 : n1;
    wa = (fc == FC_READ_WRITE) ? a2 : a1;
    len = (fc == FC_WRITE_MULTI) ? WR_LEN_BASE + 2 * n : 16'h0006;
    len = (fc == FC_READ_WRITE) ? RW_LEN_BASE + 2 * n : len;
    len = len + len_adj;
    ok = bc_adj == 8'h00 && pid == 16'h0000 && uid == 8'h00 && n1 >= 16'h0001 &&
      len_adj == 16'h0000;
    ok = ok && (fc == FC_READ_WRITE ? (n1 <= RW_MAX_CNT && n2 >= 16'h0001 &&
      n2 <= RW_MAX_CNT) : n1 <= WR_MAX_CNT);
    req.delete();
    exp_q.delete();
    got.delete();
    n_wr = 0;
    n_rd = 0;
    r16(tid);
    r16(pid);
    r16(len);
    req.push_back(uid);
    req.push_back(fc);
    r16(a1);
    r16(n1);
    if (fc == FC_READ_WRITE) begin
      r16(a2);
      r16(n2);
    end
    if (isfc) begin
      req.push_back(8'(2 * n) + bc_adj);
      for (int i = 0; i < n; i++) begin
        v = 16'($random(seed));
        r16(v);
        if (ok) ref_mem[16'(wa + i)] = v;
      end
    end
    e16(tid);
    e16(16'h0000);
    if (!isfc || !ok) begin
      e16(ERR_RSP_LEN);
      e8(8'h00);
      e8(fc | EXC_FLAG);
      e8(isfc ? EXC_ILLEGAL_VALUE : EXC_ILLEGAL_FUNC);
    end else if (fc == FC_WRITE_MULTI) begin
      e16(WR_RSP_LEN);
      e8(8'h00);
      e8(fc);
      e16(a1);
      e16(n1);
    end else begin
      e16(RD_RSP_LEN_BASE + 2 * n1);
      e8(8'h00);
      e8(fc);
      e8(8'(2 * n1));
      for (int i = 0; i < n1; i++) e16(ref_mem[16'(a1 + i)]);
    end
    exp_q[exp_q.size() - 1].last = 1'b1;
    if (pid != 16'h0000 || uid != 8'h00) exp_q.delete();
    for (int i = 0; i < req.size(); i++) begin
      rx_valid <= 1'b1;
      rx <= '{data: req[i], last: i == req.size() - 1};
      do @(posedge clk); while (!(ce && rx_ready));
      #1;
    end
    rx_valid <= 1'b0;
    repeat (exp_q.size() == 0 ? 40 : 0) @(posedge clk);
    t = 0;
    while (got.size() < exp_q.size() && t < 3000) begin
      @(posedge clk);
      t++;
    end
    repeat (4) @(posedge clk);
    #1;
    check({name, " size"}, 16'(got.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) begin
      if (i < got.size()) check({name, " byte"}, 16'(got[i]), 16'(exp_q[i]));
    end
    for (int i = 0; i <= n && isfc; i++) begin
      check({name, " reg"}, u_reg.mem[16'(wa + i)], ref_mem[16'(wa + i)]);
    end
    check({name, " writes"}, 16'(n_wr), (ok && isfc) ? n : 16'h0000);
    check({name, " reads"}, 16'(n_rd), (ok && fc == FC_READ_WRITE) ? n1 : 16'h0000);
    $display("test %s done", name);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    tx_ready = 1'b1;
    rx = '0;
    rx_valid = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    cycles = 0;
    len_adj = 16'h0000;
    for (int i = 0; i < 65536; i++) ref_mem[i] = 16'(i) ^ 16'hA5C3;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    ra = 16'($random(seed));
    frame(FC_WRITE_MULTI, 16'h1770, 16'h0002, 0, 0, 0, 0, 0, "wr_example");
    frame(FC_WRITE_MULTI, ra, WR_MAX_CNT, 0, 0, 0, 0, 0, "wr_max");
    frame(FC_WRITE_MULTI, ra, WR_MAX_CNT + 1, 0, 0, 0, 0, 0, "wr_over");
    frame(FC_WRITE_MULTI, ra, 16'h0000, 0, 0, 0, 0, 0, "wr_zero");
    frame(FC_WRITE_MULTI, ra, 16'h0003, 0, 0, 8'h01, 0, 0, "wr_bytecnt");
    frame(FC_READ_WRITE, 16'h1388, 2, 16'h1770, 2, 0, 0, 0, "rw_example");
    frame(FC_READ_WRITE, ra, RW_MAX_CNT, ra + 16'h4000, 1, 0, 0, 0, "rw_max_rd");
    frame(FC_READ_WRITE, ra, 1, ra + 16'h4000, RW_MAX_CNT, 0, 0, 0, "rw_max_wr");
    frame(FC_READ_WRITE, ra, 1, ra + 16'h4000, RW_MAX_CNT + 1, 0, 0, 0, "rw_over");
    frame(FC_READ_WRITE, ra, RW_MAX_CNT + 1, ra + 16'h4000, 1, 0, 0, 0, "rw_rd_over");
    frame(FC_READ_WRITE, ra, 2, ra + 16'h4000, 2, 8'hFF, 0, 0, "rw_bytecnt");
    len_adj = 16'h0001;
    frame(FC_WRITE_MULTI, ra, 16'h0002, 0, 0, 0, 0, 0, "wr_badlen");
    frame(FC_READ_WRITE, ra, 2, ra + 16'h4000, 2, 0, 0, 0, "rw_badlen");
    len_adj = 16'h0000;
    frame(8'h03, ra, 16'h0002, 0, 0, 0, 0, 0, "func_other");
    frame(FC_WRITE_MULTI, ra, 16'h0002, 0, 0, 0, 16'h0001, 0, "proto_id");
    frame(FC_WRITE_MULTI, ra, 16'h0002, 0, 0, 0, 0, 8'h01, "unit_id");
    frame(FC_WRITE_MULTI, ra, 16'h0001, 0, 0, 0, 0, 0, "wr_single");
    give_verdict();
  end
endmodule
